/* src/asmc_params.svh */
// timing counts, edge thresholds and reset values for the serial mode control block
`ifndef ASMC_PARAMS_SVH
`define ASMC_PARAMS_SVH

// serial-clock falling-edge thresholds that pick the next mode, start tracking and capture the select bits
`define ASMC_EDGE_GLITCH 5'h02
`define ASMC_EDGE_PWR 5'h0a
`define ASMC_EDGE_CHAIN_END 5'h0c
`define ASMC_EDGE_NORMAL 5'h0d
`define ASMC_EDGE_TRACK 5'h05
`define ASMC_EDGE_CHN 5'h03
`define ASMC_EDGE_STY 5'h04
`define ASMC_EDGE_FULL 5'h10
// leading bits ahead of the result: two zeros, channel, then channel again (inverted in chain mode)
`define ASMC_LEAD_BITS 5'h04
`define ASMC_RESULT_BITS 12
// power-up time in ns and its count of system clocks
`define ASMC_PWRUP_NS 1000
`define ASMC_CLK_NS 10
`define ASMC_PWRUP_CYC 8'h64
// reset values
`define ASMC_RST_COUNT 5'h00
`define ASMC_RST_CHN 1'b0

`endif

/* src/asmc_pkg.sv */
// types shared by the serial mode control block
package asmc_pkg;

    // operating modes, gray coded along normal -> chain -> power-down
    typedef enum logic [1:0] {
        ASMC_NORMAL = 2'b00,
        ASMC_CHAIN = 2'b01,
        ASMC_PWRDN = 2'b11
    } asmc_mode_t;

endpackage : asmc_pkg

/* src/asmc_core.sv */
// mode control, conversion framing and serial data output of a two-channel serial converter
`timescale 1ns/100ps
`include "asmc_params.svh"

module asmc_core (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic [11:0] result_i,
    input wire logic chain_din_valid_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic analog_off_o,
    output logic track_o,
    output logic sample_o,
    output logic conv_abort_o,
    output logic powered_o,
    output logic chain_data_valid_o,
    output logic [1:0] mode_o,
    output logic channel_o
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------

    logic [2:0] cs_sync;
    logic [2:0] sclk_sync;
    logic [2:0] din_sync;
    logic cs_b;
    logic sclk;

    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h7;
            din_sync <= 3'h0;
        end
        else
        begin
            cs_sync <= {cs_sync[1:0], cs_b_i};
            sclk_sync <= {sclk_sync[1:0], sclk_i};
            din_sync <= {din_sync[1:0], din_i};
        end
    end

    // filtered levels, updated only when the later two stages agree
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cs_b <= 1'b1;
            sclk <= 1'b1;
        end
        else
        begin
            if (cs_sync[1] == cs_sync[2])
                cs_b <= cs_sync[2];
            if (sclk_sync[1] == sclk_sync[2])
                sclk <= sclk_sync[2];
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    assign cs_fall = cs_b && (cs_sync[1] == cs_sync[2]) && !cs_sync[2];
    assign cs_rise = !cs_b && (cs_sync[1] == cs_sync[2]) && cs_sync[2];
    assign sclk_fall = !cs_b && sclk && (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2];

    // ------------------------------------------------------------------
    // frame counting and input word capture
    // ------------------------------------------------------------------

    logic [4:0] edge_count;
    logic chn_in;
    logic sty_in;
    logic [4:0] next_count;
    assign next_count = (edge_count == 5'h1f) ? edge_count : edge_count + 5'h01;

    // falling-edge counter, cleared at frame start, saturating
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            edge_count <= `ASMC_RST_COUNT;
        else if (cs_fall)
            edge_count <= `ASMC_RST_COUNT;
        else if (sclk_fall)
            edge_count <= next_count;
    end

    // capture the two used bits of the input word
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            chn_in <= `ASMC_RST_CHN;
            sty_in <= `ASMC_RST_CHN;
        end
        else if (sclk_fall && next_count == `ASMC_EDGE_CHN)
            chn_in <= din_sync[2];
        else if (sclk_fall && next_count == `ASMC_EDGE_STY)
            sty_in <= din_sync[2];
    end

    // ------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------

    asmc_pkg::asmc_mode_t mode;
    asmc_pkg::asmc_mode_t next_mode;
    logic frame_mode_chain;
    logic frame_from_pd;
    logic full_frame;

    // mode on rising chip-select from the edge count
    always_comb
    begin
        next_mode = mode;
        full_frame = edge_count >= `ASMC_EDGE_FULL;
        if (edge_count < `ASMC_EDGE_GLITCH)
            next_mode = frame_from_pd ? asmc_pkg::ASMC_PWRDN : mode;
        else if (edge_count < `ASMC_EDGE_PWR)
            next_mode = asmc_pkg::ASMC_PWRDN;
        else if (frame_from_pd || frame_mode_chain)
            // wake or chain dummy frame: 10..13 back to normal from chain, 10..11 into chain from wake
            next_mode = (frame_mode_chain && edge_count <= `ASMC_EDGE_NORMAL)
                ? asmc_pkg::ASMC_NORMAL
                : (edge_count < `ASMC_EDGE_CHAIN_END) ? asmc_pkg::ASMC_CHAIN
                : (frame_mode_chain && chn_in != sty_in && full_frame) ? asmc_pkg::ASMC_CHAIN
                : asmc_pkg::ASMC_NORMAL;
        else if (edge_count <= `ASMC_EDGE_NORMAL)
            next_mode = asmc_pkg::ASMC_CHAIN;
        else
            next_mode = asmc_pkg::ASMC_NORMAL;
    end

    // mode register, updated at the end of each frame
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            mode <= asmc_pkg::ASMC_NORMAL;
        else if (cs_rise)
            mode <= next_mode;
    end

    // remember which mode the frame began in
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            frame_mode_chain <= 1'b0;
            frame_from_pd <= 1'b0;
        end
        else if (cs_fall)
        begin
            frame_mode_chain <= (mode == asmc_pkg::ASMC_CHAIN);
            frame_from_pd <= (mode == asmc_pkg::ASMC_PWRDN);
        end
    end

    // ------------------------------------------------------------------
    // analog power, track-and-hold and conversion strobes
    // ------------------------------------------------------------------

    logic [7:0] pwr_count;
    logic in_frame;
    logic pwr_ok;

    // analog off while powered down and not in a frame; wakes on frame start
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            analog_off_o <= 1'b1;
        else if (cs_fall)
            analog_off_o <= 1'b0;
        else if (cs_rise)
            analog_off_o <= (next_mode == asmc_pkg::ASMC_PWRDN);
    end

    // power-up timer; sixteen edges of a wake frame also count as powered
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || analog_off_o)
            pwr_count <= 8'h00;
        else if (pwr_count != `ASMC_PWRUP_CYC)
            pwr_count <= pwr_count + 8'h01;
    end
    assign pwr_ok = (pwr_count == `ASMC_PWRUP_CYC);

    // powered flag for valid next conversion; drops in the same cycle as the shut-off
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || analog_off_o || (cs_rise && next_mode == asmc_pkg::ASMC_PWRDN))
            powered_o <= 1'b0;
        else if (pwr_ok || (sclk_fall && next_count == `ASMC_EDGE_FULL))
            powered_o <= 1'b1;
    end

    // track-and-hold: hold from reset and at sampling, track on fifth edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            track_o <= 1'b0;
        else if (cs_fall)
            track_o <= 1'b0;
        else if (cs_rise && next_mode == asmc_pkg::ASMC_PWRDN)
            track_o <= 1'b0;
        else if (sclk_fall && next_count == `ASMC_EDGE_TRACK)
            track_o <= 1'b1;
    end

    // one-cycle sample and abort strobes
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sample_o <= 1'b0;
            conv_abort_o <= 1'b0;
            in_frame <= 1'b0;
        end
        else
        begin
            sample_o <= cs_fall;
            conv_abort_o <= cs_rise && !full_frame;
            if (cs_fall)
                in_frame <= 1'b1;
            else if (cs_rise)
                in_frame <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // output word and data pin
    // ------------------------------------------------------------------

    logic [15:0] shift;

    // load word at frame start; shift on each falling edge
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            shift <= 16'h0000;
        else if (cs_fall)
            shift <= {2'b00, channel_o, (mode == asmc_pkg::ASMC_CHAIN) ? !channel_o : channel_o,
                      result_i};
        else if (sclk_fall)
            shift <= {shift[14:0], din_sync[2]};
    end

    // data pin driven only inside a frame
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            dout_o <= 1'b0;
            dout_oe_o <= 1'b0;
        end
        else
        begin
            dout_oe_o <= in_frame && !cs_rise;
            dout_o <= shift[15];
        end
    end

    // channel for next conversion, mode and chain validity
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            channel_o <= `ASMC_RST_CHN;
            mode_o <= 2'b00;
            chain_data_valid_o <= 1'b0;
        end
        else
        begin
            mode_o <= mode;
            if (cs_rise && edge_count >= `ASMC_EDGE_STY)
                channel_o <= chn_in;
            if (cs_rise && next_mode == asmc_pkg::ASMC_CHAIN)
                chain_data_valid_o <= chain_din_valid_i
                    && (edge_count < `ASMC_EDGE_CHAIN_END);
        end
    end

endmodule : asmc_core

/* test/asmc_core_props.sv */
// concurrent checks on the ports of the serial mode control block
`timescale 1ns/100ps
module asmc_core_props (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic sclk_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic analog_off_o,
    input wire logic track_o,
    input wire logic sample_o,
    input wire logic conv_abort_o,
    input wire logic powered_o,
    input wire logic [1:0] mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    // frame start: one pulse, caused by a chip-select fall, output driven, input held
    chk_sample_pulse: assert property (sample_o |=> !sample_o)
        else $error("sample pulse longer than one cycle");
    chk_sample_cause: assert property (sample_o |-> !cs_b_i && $past(cs_b_i, 8))
        else $error("sample without a chip-select fall");
    chk_start_drive: assert property (sample_o |-> !track_o ##1 dout_oe_o)
        else $error("frame start without drive or hold");
    // aborts and idle time leave the output floating
    chk_abort_float: assert property (conv_abort_o |=> !dout_oe_o)
        else $error("output still driven after abort");
    chk_abort_pulse: assert property (conv_abort_o |=> !conv_abort_o)
        else $error("abort pulse longer than one cycle");
    chk_idle_float: assert property (cs_b_i [*8] |-> !dout_oe_o)
        else $error("output driven while deselected");
    // power-down keeps the analog part off and unpowered
    chk_pd_analog: assert property (cs_b_i [*8] ##0 (mode_o == asmc_pkg::ASMC_PWRDN)
        |-> analog_off_o && !track_o)
        else $error("power-down without analog shut-off");
    chk_off_unpowered: assert property (analog_off_o |-> !powered_o)
        else $error("powered while analog is off");
    chk_mode_code: assert property (mode_o != 2'b10)
        else $error("illegal mode code");

    cover property (sample_o);
    cover property (conv_abort_o);
    cover property ($rose(analog_off_o));
    cover property (mode_o == asmc_pkg::ASMC_CHAIN);
endmodule : asmc_core_props

bind asmc_core asmc_core_props u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .sclk_i(sclk_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .analog_off_o(analog_off_o),
    .track_o(track_o), .sample_o(sample_o), .conv_abort_o(conv_abort_o),
    .powered_o(powered_o), .mode_o(mode_o));

/* test/asmc_host_model.sv */
// serial master model framing chip-select, serial clock and input word
`timescale 1ns/100ps
module asmc_host_model (
    output logic cs_b_o,
    output logic sclk_o,
    output logic din_o,
    input wire logic dout_i
);
    // idle high between frames, clock parked high
    initial
    begin
        cs_b_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end

    // one frame of n clock falls; reply bit captured just before each fall
    task automatic frame(input int n, input logic [15:0] w, output logic [15:0] rd);
        rd = 16'h0000;
        #1 cs_b_o = 1'b0; // offset keeps every pin change off the system clock edge
        #200;
        for (int i = 0; i < n; i++)
        begin
            din_o = w[15 - i];
            rd[15 - i] = dout_i;
            #62.5 sclk_o = 1'b0;
            #62.5 sclk_o = 1'b1;
        end
        #100 cs_b_o = 1'b1;
        din_o = ~din_o; // a released line shows no stale value
        #300;
    endtask : frame
endmodule : asmc_host_model

/* test/tb_top.sv */
// self-checking bench for the serial mode control block
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
            num_errors++; \
        end \
    end
module tb_top;
    localparam logic [1:0] md_nrm = asmc_pkg::ASMC_NORMAL;
    localparam logic [1:0] md_chn = asmc_pkg::ASMC_CHAIN;
    localparam logic [1:0] md_pd = asmc_pkg::ASMC_PWRDN;
    logic clk_i, rst_b_i, cs_b, sclk, din, cdv, dout, oe, aoff, trk, smp, abt, pwr, cvld, channel_select_bit;
    logic [11:0] res;
    logic [1:0] mode, m, e;
    logic [15:0] w, rd;
    logic known, ec;
    int seed, num_errors, n_checks, n, t;
    int cn[16] = '{1, 16, 16, 5, 9, 16, 11, 16, 13, 12, 2, 10, 12, 16, 16, 14};
    int tab[10] = '{1, 2, 5, 9, 10, 11, 12, 13, 14, 16};

    asmc_core dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk), .din_i(din),
        .result_i(res), .chain_din_valid_i(cdv), .dout_o(dout), .dout_oe_o(oe),
        .analog_off_o(aoff), .track_o(trk), .sample_o(smp), .conv_abort_o(abt),
        .powered_o(pwr), .chain_data_valid_o(cvld), .mode_o(mode), .channel_o(channel_select_bit));
    asmc_host_model host (.cs_b_o(cs_b), .sclk_o(sclk), .din_o(din),
        .dout_i(oe ? dout : 1'bz));

    // next mode from current mode, fall count and the two input select bits
    function automatic logic [1:0] exp_mode(input logic [1:0] md, input int k, input logic c,
        input logic s);
        if (md == md_pd)
            return k < 10 ? md_pd : (k < 12 ? md_chn : md_nrm);
        if (k < 2)
            return md;
        if (k < 10)
            return md_pd;
        if (md == md_chn)
            return (k < 14 || c == s) ? md_nrm : md_chn;
        return k < 14 ? md_chn : md_nrm;
    endfunction : exp_mode

    task results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // cut a hung run short
    initial
    begin
        repeat (100000) @(posedge clk_i);
        num_errors++;
        $display("wrong value run_time exp done got hung");
        results();
    end

    // corner frames first, then random fall counts and words
    initial
    begin
        seed = 35;
        num_errors = 0;
        n_checks = 0;
        rst_b_i = 1'b0;
        res = 12'h000;
        cdv = 1'b1;
        m = md_nrm;
        known = 1'b0;
        ec = 1'b0;
        repeat (10) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (t = 0; t < 56; t++)
        begin
            n = t < 16 ? cn[t] : tab[$unsigned($random(seed)) % 10];
            if (m == md_chn && n == 14)
                n = 16;
            w = $random(seed);
            @(negedge clk_i);
            res = $random(seed);
            cdv = $random(seed);
            host.frame(n, w, rd);
            e = exp_mode(m, n, w[13], w[12]);
            `CHK("mode", e, mode)
            `CHK("oe", 1'b0, oe)
            if (e == md_pd)
                `CHK("analog_off", 1'b1, aoff)
            if (e == md_pd)
                `CHK("unpowered", 1'b0, pwr)
            `CHK("track", n >= 5 && e != md_pd, trk)
            if (m == md_pd && e == md_nrm)
                `CHK("powered", 1'b1, pwr)
            if (m == md_nrm && e == md_chn)
                `CHK("chain_valid", n < 12 && cdv, cvld)
            if (m == md_nrm && n == 16 && known)
                `CHK("word", {2'b00, ec, ec, res}, rd)
            if (m == md_nrm && n == 16)
                `CHK("channel", w[13], channel_select_bit)
            known = m == md_nrm && n == 16;
            ec = w[13];
            $display("frame %0d edges %0d mode %0d", t, n, e);
            m = e;
        end
        results();
    end
endmodule : tb_top
